// ==== verilog/cfs_consts.vh ====
`ifndef CFS_CONSTS_VH
`define CFS_CONSTS_VH
// register byte offsets
`define CFS_REG_RETRY 8'h00
`define CFS_REG_INTERVAL 8'h04
`define CFS_REG_STOPMODE 8'h08
`define CFS_REG_PROTO 8'h0c
`define CFS_REG_EXTDISP 8'h10
`define CFS_REG_TERM_A 8'h14
`define CFS_REG_TERM_B 8'h18
`define CFS_REG_TERM_C 8'h1c
`define CFS_REG_STATUS 8'h20
`define CFS_REG_INT_STAT 8'h24
`define CFS_REG_INT_MASK 8'h28
`define CFS_REG_FAULT_CLR 8'h2c
// reset values
`define CFS_RETRY_RST 16'h0001
`define CFS_INTERVAL_RST 16'h0000
`define CFS_STOPMODE_RST 2'h0
// special settings
`define CFS_OFF_VALUE 16'h270f
`define CFS_RETRY_MAX 16'h000a
`define CFS_INTERVAL_MAX 16'h270e
`define CFS_STOP_COAST 2'h0
`define CFS_STOP_DECEL 2'h1
`define CFS_STOP_RESTART 2'h2
`define CFS_TERM_ALARM_HI 8'h62
`define CFS_TERM_ALARM_LO 8'hc6
// interrupt status bits
`define CFS_INT_TRIP 0
`define CFS_INT_ALARM 1
`define CFS_INT_RESTART 2
// timing: 0.1 s tick at 40 MHz
`define CFS_TICK_MS 100
`define CFS_CLK_KHZ 40000
`define CFS_TICK_CYCLES (`CFS_TICK_MS * `CFS_CLK_KHZ)
`endif

// ==== verilog/cfs_tick_gen.v ====
`timescale 1ns/1ps
`default_nettype none
module cfs_tick_gen #(
  parameter [31:0] TICK_CYCLES = 32'd4000000
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // tick out
  output reg tick
);
  reg [31:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r >= TICK_CYCLES - 32'd1) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'd1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/cfs_term_map.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.vh"
module cfs_term_map (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // alarm and terminal functions
  input wire alarm,
  input wire [23:0] term_func,
  // terminal levels
  output reg [2:0] term_out
);
  function term_level;
    input [7:0] code;
    input a;
    begin
      if (code == `CFS_TERM_ALARM_HI) begin
        term_level = a;
      end else if (code == `CFS_TERM_ALARM_LO) begin
        term_level = ~a;
      end else begin
        term_level = 1'b0;
      end
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_term
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          term_out[i] <= 1'b0;
        end else begin
          term_out[i] <= term_level(term_func[i*8 +: 8], alarm);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verilog/cfs_comm_fault_supervisor.v ====
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.vh"
module cfs_comm_fault_supervisor #(
  parameter [31:0] TICK_CYCLES = `CFS_TICK_CYCLES
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // link receive events
  input wire rx_msg_ok,
  input wire rx_msg_err,
  // drive status
  input wire network_command_mode,
  input wire decel_done,
  input wire run_cmd_in,
  input wire [15:0] speed_cmd_in,
  // drive control
  output reg coast_req,
  output reg decel_req,
  output reg restart_req,
  output reg run_cmd_out,
  output reg [15:0] speed_cmd_out,
  // fault indication
  output reg comm_fault_trip_code,
  output reg fault_output_signal,
  output reg history_commit,
  output reg history_temp,
  output reg minor_comm_alarm,
  output wire [2:0] term_out,
  output reg irq
);
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_DECEL = 2'd1;
  localparam [1:0] ST_HELD = 2'd2;

  reg [15:0] retry_limit_setting;
  reg [15:0] check_interval_setting;
  reg [1:0] stop_mode_setting;
  reg proto_modbus_r;
  reg [7:0] extended_display_select;
  reg [23:0] term_func_r;
  reg [2:0] int_stat_r;
  reg [2:0] int_mask_r;
  reg [3:0] err_cnt_r;
  reg retry_err_r;
  reg armed_r;
  reg [15:0] loss_cnt_r;
  reg [1:0] state_r;
  reg [1:0] fmode_r;
  reg saved_run_r;
  reg [15:0] saved_speed_r;
  reg [1:0] state_nxt;
  reg [31:0] rd_nxt;
  reg map_nxt;

  wire tick;
  wire any_msg = rx_msg_ok | rx_msg_err;
  wire wr_en = psel & penable & pready & pwrite;
  wire unlocked = (extended_display_select == 8'h00);
  wire fault_clr_wr = wr_en & (paddr == `CFS_REG_FAULT_CLR) & pwdata[0];
  wire retry_on = ~proto_modbus_r & (retry_limit_setting != `CFS_OFF_VALUE);
  wire [3:0] err_cnt_inc = (err_cnt_r == 4'hf) ? err_cnt_r : err_cnt_r + 4'd1;
  wire retry_trip = retry_on & rx_msg_err & ({12'h0, err_cnt_inc} > retry_limit_setting);
  wire loss_zero = (check_interval_setting == 16'h0000) & network_command_mode;
  wire loss_timed = armed_r & (check_interval_setting != `CFS_OFF_VALUE) &
                    (check_interval_setting != 16'h0000) &
                    (loss_cnt_r > check_interval_setting);
  wire err_cond = retry_err_r | retry_trip | loss_zero | loss_timed;
  wire restart_now = (fmode_r == `CFS_STOP_RESTART) & ~err_cond;

  cfs_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  cfs_term_map u_term (
    .pclk(pclk),
    .presetn(presetn),
    .alarm(minor_comm_alarm),
    .term_func(term_func_r),
    .term_out(term_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb read decode
  always @* begin
    rd_nxt = 32'h0;
    map_nxt = 1'b1;
    if (paddr == `CFS_REG_RETRY) begin
      rd_nxt = {16'h0, retry_limit_setting};
    end else if (paddr == `CFS_REG_INTERVAL) begin
      rd_nxt = {16'h0, check_interval_setting};
    end else if (paddr == `CFS_REG_STOPMODE) begin
      rd_nxt = {30'h0, stop_mode_setting};
    end else if (paddr == `CFS_REG_PROTO) begin
      rd_nxt = {31'h0, proto_modbus_r};
    end else if (paddr == `CFS_REG_EXTDISP) begin
      rd_nxt = {24'h0, extended_display_select};
    end else if (paddr == `CFS_REG_TERM_A) begin
      rd_nxt = {24'h0, term_func_r[7:0]};
    end else if (paddr == `CFS_REG_TERM_B) begin
      rd_nxt = {24'h0, term_func_r[15:8]};
    end else if (paddr == `CFS_REG_TERM_C) begin
      rd_nxt = {24'h0, term_func_r[23:16]};
    end else if (paddr == `CFS_REG_STATUS) begin
      rd_nxt = {16'h0, loss_cnt_r[7:0], err_cnt_r, state_r, minor_comm_alarm,
                comm_fault_trip_code};
    end else if (paddr == `CFS_REG_INT_STAT) begin
      rd_nxt = {29'h0, int_stat_r};
    end else if (paddr == `CFS_REG_INT_MASK) begin
      rd_nxt = {29'h0, int_mask_r};
    end else if (paddr == `CFS_REG_FAULT_CLR) begin
      rd_nxt = 32'h0;
    end else begin
      map_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      retry_limit_setting <= `CFS_RETRY_RST;
      check_interval_setting <= `CFS_INTERVAL_RST;
      stop_mode_setting <= `CFS_STOPMODE_RST;
      proto_modbus_r <= 1'b0;
      extended_display_select <= 8'h00;
      term_func_r <= 24'h0;
      int_mask_r <= 3'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_nxt;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0 : rd_nxt;
      end
      if (wr_en & map_nxt) begin
        if (paddr == `CFS_REG_RETRY) begin
          if (unlocked & ((pwdata[15:0] <= `CFS_RETRY_MAX) |
              (pwdata[15:0] == `CFS_OFF_VALUE))) begin
            retry_limit_setting <= pwdata[15:0];
          end
        end else if (paddr == `CFS_REG_INTERVAL) begin
          if (unlocked & (pwdata[31:16] == 16'h0) &
              (pwdata[15:0] <= `CFS_OFF_VALUE)) begin
            check_interval_setting <= pwdata[15:0];
          end
        end else if (paddr == `CFS_REG_STOPMODE) begin
          if (unlocked & (pwdata[1:0] <= `CFS_STOP_RESTART)) begin
            stop_mode_setting <= pwdata[1:0];
          end
        end else if (paddr == `CFS_REG_PROTO) begin
          proto_modbus_r <= pwdata[0];
        end else if (paddr == `CFS_REG_EXTDISP) begin
          extended_display_select <= pwdata[7:0];
        end else if (paddr == `CFS_REG_TERM_A) begin
          term_func_r[7:0] <= pwdata[7:0];
        end else if (paddr == `CFS_REG_TERM_B) begin
          term_func_r[15:8] <= pwdata[7:0];
        end else if (paddr == `CFS_REG_TERM_C) begin
          term_func_r[23:16] <= pwdata[7:0];
        end else if (paddr == `CFS_REG_INT_MASK) begin
          int_mask_r <= pwdata[2:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive error run and signal loss supervision
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= 4'h0;
      retry_err_r <= 1'b0;
      minor_comm_alarm <= 1'b0;
      armed_r <= 1'b0;
      loss_cnt_r <= 16'h0;
    end else begin
      if (proto_modbus_r) begin
        err_cnt_r <= 4'h0;
        retry_err_r <= 1'b0;
        minor_comm_alarm <= 1'b0;
      end else if (rx_msg_ok) begin
        err_cnt_r <= 4'h0;
        retry_err_r <= 1'b0;
        minor_comm_alarm <= 1'b0;
      end else if (rx_msg_err) begin
        err_cnt_r <= err_cnt_inc;
        if (retry_trip) begin
          retry_err_r <= 1'b1;
        end
        minor_comm_alarm <= (retry_limit_setting == `CFS_OFF_VALUE);
      end
      if (!network_command_mode || check_interval_setting == `CFS_OFF_VALUE) begin
        armed_r <= 1'b0;
        loss_cnt_r <= 16'h0;
      end else if (any_msg) begin
        armed_r <= 1'b1;
        loss_cnt_r <= 16'h0;
      end else if (armed_r && tick && loss_cnt_r != 16'hffff) begin
        loss_cnt_r <= loss_cnt_r + 16'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault response sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (err_cond) begin
          state_nxt = (stop_mode_setting == `CFS_STOP_COAST) ? ST_HELD : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (restart_now) begin
          state_nxt = ST_RUN;
        end else if (decel_done) begin
          state_nxt = ST_HELD;
        end
      end
      ST_HELD: begin
        if (restart_now || (fault_clr_wr && fmode_r != `CFS_STOP_RESTART)) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      fmode_r <= `CFS_STOP_COAST;
      saved_run_r <= 1'b0;
      saved_speed_r <= 16'h0;
      coast_req <= 1'b0;
      decel_req <= 1'b0;
      restart_req <= 1'b0;
      run_cmd_out <= 1'b0;
      speed_cmd_out <= 16'h0;
      comm_fault_trip_code <= 1'b0;
      fault_output_signal <= 1'b0;
      history_commit <= 1'b0;
      history_temp <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_RUN && state_nxt != ST_RUN) begin
        fmode_r <= stop_mode_setting;
        saved_run_r <= run_cmd_in;
        saved_speed_r <= speed_cmd_in;
      end
      restart_req <= (state_r != ST_RUN) && (state_nxt == ST_RUN) && restart_now;
      if (state_nxt == ST_RUN) begin
        run_cmd_out <= (state_r != ST_RUN) ? saved_run_r : run_cmd_in;
        speed_cmd_out <= (state_r != ST_RUN) ? saved_speed_r : speed_cmd_in;
      end else begin
        run_cmd_out <= 1'b0;
        speed_cmd_out <= (state_r == ST_RUN) ? speed_cmd_in : saved_speed_r;
      end
      coast_req <= (state_nxt == ST_HELD) && ((state_r == ST_RUN) ?
                   (stop_mode_setting == `CFS_STOP_COAST) : (fmode_r == `CFS_STOP_COAST));
      decel_req <= (state_nxt == ST_DECEL);
      comm_fault_trip_code <= (state_nxt == ST_HELD);
      fault_output_signal <= (state_nxt == ST_HELD) &&
                             (state_r == ST_RUN || fmode_r != `CFS_STOP_RESTART);
      history_commit <= (state_nxt == ST_HELD) && (state_r != ST_HELD) &&
                        (state_r == ST_RUN || fmode_r != `CFS_STOP_RESTART);
      history_temp <= (state_nxt == ST_HELD) && (state_r != ST_RUN) &&
                      (fmode_r == `CFS_STOP_RESTART);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  wire [2:0] int_set = {restart_req, rx_msg_err & minor_comm_alarm,
                        (state_r == ST_RUN) & (state_nxt != ST_RUN)};
  wire [2:0] int_clr = (wr_en && paddr == `CFS_REG_INT_STAT) ? pwdata[2:0] : 3'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;
      irq <= |(((int_stat_r & ~int_clr) | int_set) & int_mask_r);
    end
  end
endmodule
`default_nettype wire

// ==== tb/cfs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfs_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // link and drive
  input wire logic rx_msg_ok,
  input wire logic rx_msg_err,
  input wire logic coast_req,
  input wire logic decel_req,
  input wire logic restart_req,
  // fault indication
  input wire logic comm_fault_trip_code,
  input wire logic fault_output_signal,
  input wire logic history_commit,
  input wire logic history_temp,
  input wire logic minor_comm_alarm
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_APB_READY: assert property (s_setup |=> s_access) else $error("no ready in access");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
  AST_SLVERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_COAST_HELD: assert property (coast_req |-> comm_fault_trip_code && fault_output_signal
    && !decel_req) else $error("coast without fault");
  AST_DECEL_NO_OUT: assert property (decel_req |-> !fault_output_signal)
    else $error("fault output during decel");
  AST_COMMIT: assert property ($rose(fault_output_signal) |-> history_commit)
    else $error("output without commit");
  AST_TEMP: assert property (history_temp |-> comm_fault_trip_code && !fault_output_signal
    && !history_commit) else $error("temporary record wrong");
  AST_ALARM_CLR: assert property (rx_msg_ok && !rx_msg_err |=> !minor_comm_alarm)
    else $error("alarm not cleared");
  AST_RESTART: assert property (restart_req |-> !coast_req ##1 !restart_req)
    else $error("restart pulse wrong");
endmodule
bind cfs_comm_fault_supervisor cfs_monitor cfs_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .rx_msg_ok(rx_msg_ok),
  .rx_msg_err(rx_msg_err), .coast_req(coast_req), .decel_req(decel_req),
  .restart_req(restart_req), .comm_fault_trip_code(comm_fault_trip_code),
  .fault_output_signal(fault_output_signal), .history_commit(history_commit),
  .history_temp(history_temp), .minor_comm_alarm(minor_comm_alarm));
`default_nettype wire

// ==== tb/cfs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfs_host_model (
  // clock
  input wire logic pclk,
  // received message events
  output logic rx_msg_ok,
  output logic rx_msg_err
);
  initial begin
    rx_msg_ok = 1'b0;
    rx_msg_err = 1'b0;
  end
  // one message, then gap cycles of silence; regular calls keep the link alive
  task automatic send(input logic good, input int gap);
    @(posedge pclk);
    rx_msg_ok <= good;
    rx_msg_err <= !good;
    @(posedge pclk);
    rx_msg_ok <= 1'b0;
    rx_msg_err <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_msg_ok, rx_msg_err, network_command_mode, decel_done, run_cmd_in, run_cmd_out;
  logic [15:0] speed_cmd_in, speed_cmd_out;
  logic coast_req, decel_req, restart_req, comm_fault_trip_code, fault_output_signal;
  logic history_commit, history_temp, minor_comm_alarm;
  logic [2:0] term_out;
  logic [4:0] flags;
  int n_mismatch, checks_done, i;
  assign flags = {restart_req, decel_req, fault_output_signal, coast_req, comm_fault_trip_code};
  cfs_comm_fault_supervisor #(.TICK_CYCLES(32'd20)) cfs_comm_fault_supervisor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_msg_ok(rx_msg_ok), .rx_msg_err(rx_msg_err),
    .network_command_mode(network_command_mode), .decel_done(decel_done),
    .run_cmd_in(run_cmd_in), .speed_cmd_in(speed_cmd_in), .coast_req(coast_req),
    .decel_req(decel_req), .restart_req(restart_req), .run_cmd_out(run_cmd_out),
    .speed_cmd_out(speed_cmd_out), .comm_fault_trip_code(comm_fault_trip_code),
    .fault_output_signal(fault_output_signal), .history_commit(history_commit),
    .history_temp(history_temp), .minor_comm_alarm(minor_comm_alarm), .term_out(term_out),
    .irq(irq));
  cfs_host_model host_i (.pclk(pclk), .rx_msg_ok(rx_msg_ok), .rx_msg_err(rx_msg_err));
  always #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // polls one fault flag with a bound
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    while (flags[k] !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chkb("flag wait", flags[k], 1'b1);
    if (n == 300) final_report();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chkb("pready", pready, 1'b1);
      final_report();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", r, exp);
    chkb("pslverr", e, eexp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    network_command_mode = 0; decel_done = 0; run_cmd_in = 0; speed_cmd_in = 0;
    n_mismatch = 0; checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`CFS_REG_RETRY, 32'h1, 1'b0);
    rdc(`CFS_REG_INTERVAL, 32'h0, 1'b0);
    rdc(`CFS_REG_STOPMODE, 32'h0, 1'b0);
    rdc(8'h30, 32'h0, 1'b1);
    wr(`CFS_REG_EXTDISP, 32'h1);
    wr(`CFS_REG_RETRY, 32'h5);
    rdc(`CFS_REG_RETRY, 32'h1, 1'b0);
    wr(`CFS_REG_EXTDISP, 32'h0);
    wr(`CFS_REG_RETRY, 32'hb);
    rdc(`CFS_REG_RETRY, 32'h1, 1'b0);
    wr(`CFS_REG_RETRY, 32'h2);
    wr(`CFS_REG_INTERVAL, `CFS_OFF_VALUE);
    wr(`CFS_REG_INT_MASK, 32'h1);
    network_command_mode <= 1'b1;
    host_i.send(0, 3); host_i.send(0, 3); host_i.send(1, 3); host_i.send(0, 3);
    host_i.send(0, 200);
    chkb("trip", comm_fault_trip_code, 1'b0);
    rdc(`CFS_REG_STATUS, 32'h20, 1'b0);
    host_i.send(0, 0);
    wait_hi(0);
    repeat (3) @(posedge pclk);
    chkb("coast", coast_req, 1'b1);
    chkb("irq", irq, 1'b1);
    wr(`CFS_REG_INT_STAT, 32'h1);
    chkb("irq", irq, 1'b0);
    host_i.send(1, 2);
    chkb("held", comm_fault_trip_code, 1'b1);
    wr(`CFS_REG_FAULT_CLR, 32'h1);
    chkb("trip", comm_fault_trip_code, 1'b0);
    wr(`CFS_REG_PROTO, 32'h1);
    for (i = 0; i < 4; i++) host_i.send(0, 2);
    chkb("trip", comm_fault_trip_code, 1'b0);
    host_i.send(1, 2);
    wr(`CFS_REG_PROTO, 32'h0);
    wr(`CFS_REG_RETRY, {16'h0, `CFS_OFF_VALUE});
    wr(`CFS_REG_TERM_A, 32'h62);
    wr(`CFS_REG_TERM_B, 32'hc6);
    for (i = 0; i < 4; i++) host_i.send(0, 3);
    chkb("alarm", minor_comm_alarm, 1'b1);
    chkb("trip", comm_fault_trip_code, 1'b0);
    chk("term_out", {29'h0, term_out}, 32'h1);
    host_i.send(1, 3);
    chkb("alarm", minor_comm_alarm, 1'b0);
    chk("term_out", {29'h0, term_out}, 32'h2);
    wr(`CFS_REG_RETRY, 32'h2);
    wr(`CFS_REG_INTERVAL, 32'h3);
    wr(`CFS_REG_STOPMODE, 32'h1);
    network_command_mode <= 1'b0;
    @(posedge pclk);
    network_command_mode <= 1'b1;
    repeat (200) @(posedge pclk);
    chkb("trip", comm_fault_trip_code, 1'b0);
    for (i = 0; i < 5; i++) host_i.send(1, 36);
    chkb("decel", decel_req, 1'b0);
    repeat (10) @(posedge pclk);
    chkb("decel", decel_req, 1'b0);
    wait_hi(3);
    chkb("fault out", fault_output_signal, 1'b0);
    decel_done <= 1'b1;
    wait_hi(2);
    host_i.send(1, 2);
    chkb("held", comm_fault_trip_code, 1'b1);
    wr(`CFS_REG_FAULT_CLR, 32'h1);
    decel_done <= 1'b0;
    wr(`CFS_REG_STOPMODE, 32'h2);
    run_cmd_in <= 1'b1;
    speed_cmd_in <= 16'h1234;
    host_i.send(1, 3);
    wait_hi(3);
    run_cmd_in <= 1'b0;
    speed_cmd_in <= 16'h0000;
    host_i.send(1, 0);
    wait_hi(4);
    chkb("run out", run_cmd_out, 1'b1);
    chk("speed out", {16'h0, speed_cmd_out}, 32'h1234);
    network_command_mode <= 1'b0;
    wr(`CFS_REG_STOPMODE, 32'h0);
    wr(`CFS_REG_INTERVAL, 32'h0);
    network_command_mode <= 1'b1;
    wait_hi(1);
    final_report();
  end
endmodule
`default_nettype wire
